// ==== design/decim_cfg.svh ====
// Contract
// RULE_01: two voltage paths share one stream; two current paths
// RULE_02: each path takes a one-bit modulator stream
// RULE_03: one input sample every eight clocks
// RULE_04: output words are twenty-four bits wide
// RULE_05: one output word per 1024 clocks
// RULE_06: third-order sinc decimator per path
// RULE_07: third-order IIR droop compensation after decimator
// RULE_08: signed output word with one-cycle valid strobe
`ifndef DECIM_CFG_SVH
`define DECIM_CFG_SVH

// input sample spacing, clocks of ref_clk
`define DECIM_SAMPLE_DIV   8
// input samples per output word
`define DECIM_RATIO        128
// output word width
`define DECIM_WORD_W       24
// number of filter paths
`define DECIM_NPATH        5
// path indices
`define DECIM_PATH_V1      0
`define DECIM_PATH_V2      1
`define DECIM_PATH_I1      2
`define DECIM_PATH_I2      3
`define DECIM_PATH_TEMP    4
// reset value of every word register
`define DECIM_WORD_RST     24'h00_0000
// compensation coefficients, signed Q2.14
`define DECIM_COEF_W       16
`define DECIM_COEF_FRAC    14
`define DECIM_B0           16'sh5800
`define DECIM_B1           -16'sh1400
`define DECIM_B2           16'sh0400
`define DECIM_B3           16'sh0000
`define DECIM_A1           16'sh0800
`define DECIM_A2           16'sh0000
`define DECIM_A3           16'sh0000

`endif

// ==== design/decim_pkg.sv ====
`include "decim_cfg.svh"

package decim_pkg;

    typedef logic signed [`DECIM_WORD_W-1:0] word_t;

    typedef logic signed [`DECIM_COEF_W-1:0] coef_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } seq_state_t;

endpackage

// ==== design/anti_droop_iir.sv ====
`timescale 1ns/100ps
`include "decim_cfg.svh"

module anti_droop_iir #(
    parameter int             W    = `DECIM_WORD_W,
    parameter decim_pkg::coef_t B0 = `DECIM_B0,
    parameter decim_pkg::coef_t B1 = `DECIM_B1,
    parameter decim_pkg::coef_t B2 = `DECIM_B2,
    parameter decim_pkg::coef_t B3 = `DECIM_B3,
    parameter decim_pkg::coef_t A1 = `DECIM_A1,
    parameter decim_pkg::coef_t A2 = `DECIM_A2,
    parameter decim_pkg::coef_t A3 = `DECIM_A3
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic signed [W-1:0] x0,
    input  wire logic signed [W-1:0] x1,
    input  wire logic signed [W-1:0] x2,
    input  wire logic signed [W-1:0] x3,
    input  wire logic signed [W-1:0] y1,
    input  wire logic signed [W-1:0] y2,
    input  wire logic signed [W-1:0] y3,
    output logic signed      [W-1:0] y_out
);
    localparam int AW = W + `DECIM_COEF_W + 3;

    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] scaled;
    logic signed [W-1:0]  y_ff;
    logic signed [W-1:0]  nxt_y;

    function automatic logic signed [W-1:0] sat(input logic signed [AW-1:0] v);
        logic signed [AW-1:0] hi;
        logic signed [AW-1:0] lo;
        hi = AW'({1'b0, {(W-1){1'b1}}});
        lo = -hi - AW'(1);
        if (v > hi) begin
            sat = hi[W-1:0];
        end else if (v < lo) begin
            sat = lo[W-1:0];
        end else begin
            sat = v[W-1:0];
        end
    endfunction

    // difference equation, feedback subtracts past outputs
    always_comb begin
        // operands widened first so no product is formed at word width
        acc = AW'(x0) * AW'(B0) + AW'(x1) * AW'(B1) + AW'(x2) * AW'(B2)
            + AW'(x3) * AW'(B3)
            - AW'(y1) * AW'(A1) - AW'(y2) * AW'(A2) - AW'(y3) * AW'(A3); // [RULE_07]
        scaled = acc >>> `DECIM_COEF_FRAC;
        nxt_y  = sat(scaled);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            y_ff <= `DECIM_WORD_RST;
        end else begin
            y_ff <= nxt_y;
        end
    end

    assign y_out = y_ff;

endmodule // anti_droop_iir

// ==== design/decimation_filter_front_end.sv ====
`timescale 1ns/100ps
`include "decim_cfg.svh"

module decimation_filter_front_end #(
    parameter int SAMPLE_DIV = `DECIM_SAMPLE_DIV,
    parameter int RATIO      = `DECIM_RATIO,
    parameter int W          = `DECIM_WORD_W
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                volt_mod_bit,
    input  wire logic                cur1_mod_bit,
    input  wire logic                cur2_mod_bit,
    input  wire logic                temp_mod_bit,
    output logic signed      [W-1:0] v1_word,
    output logic                     v1_valid,
    output logic signed      [W-1:0] v2_word,
    output logic                     v2_valid,
    output logic signed      [W-1:0] i1_word,
    output logic                     i1_valid,
    output logic signed      [W-1:0] i2_word,
    output logic                     i2_valid,
    output logic signed      [W-1:0] temp_word,
    output logic                     temp_valid
);
    localparam int NPATH = `DECIM_NPATH;
    localparam int PH_W  = $clog2(SAMPLE_DIV);
    localparam int SM_W  = $clog2(RATIO);
    localparam int IX_W  = $clog2(NPATH);

    function automatic logic is_last_path(input logic [IX_W-1:0] idx);
        is_last_path = (idx == IX_W'(NPATH - 1));
    endfunction

    // ---------------- sample and output-word timing
    logic [PH_W-1:0] phase_ff;
    logic [PH_W-1:0] nxt_phase;
    logic [SM_W-1:0] smp_ff;
    logic [SM_W-1:0] nxt_smp;
    logic            sample_tick;
    logic            dump;
    logic            cic_rdy_ff;
    logic            nxt_cic_rdy;

    always_comb begin
        sample_tick = (phase_ff == PH_W'(SAMPLE_DIV - 1)); // [RULE_03]
        dump        = sample_tick && (smp_ff == SM_W'(RATIO - 1)); // [RULE_05]
        nxt_phase   = phase_ff + PH_W'(1);
        nxt_smp     = sample_tick ? smp_ff + SM_W'(1) : smp_ff;
        nxt_cic_rdy = dump;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff   <= '0;
            smp_ff     <= '0;
            cic_rdy_ff <= 1'b0;
        end else begin
            phase_ff   <= nxt_phase;
            smp_ff     <= nxt_smp;
            cic_rdy_ff <= nxt_cic_rdy;
        end
    end

    // ---------------- path inputs, voltage stream feeds two paths
    logic                path_bit [NPATH];
    decim_pkg::word_t    cic_word [NPATH];

    assign path_bit[`DECIM_PATH_V1]   = volt_mod_bit; // [RULE_01]
    assign path_bit[`DECIM_PATH_V2]   = volt_mod_bit; // [RULE_01]
    assign path_bit[`DECIM_PATH_I1]   = cur1_mod_bit;
    assign path_bit[`DECIM_PATH_I2]   = cur2_mod_bit;
    assign path_bit[`DECIM_PATH_TEMP] = temp_mod_bit;

    // ---------------- sinc3 decimators, one per path
    genvar gp;
    generate
        for (gp = 0; gp < NPATH; gp++) begin : g_cic
            decim_pkg::word_t int_ff  [3];
            decim_pkg::word_t nxt_int [3];
            decim_pkg::word_t dly_ff  [3];
            decim_pkg::word_t nxt_dly [3];
            decim_pkg::word_t comb_v  [3];
            decim_pkg::word_t cic_ff;
            decim_pkg::word_t nxt_cic;
            decim_pkg::word_t x_in;

            always_comb begin
                // one bit widened to +1 or -1
                x_in    = path_bit[gp] ? W'(1) : -W'(1); // [RULE_02] [RULE_04]
                nxt_int = int_ff;
                nxt_dly = dly_ff;
                nxt_cic = cic_ff;
                comb_v[0] = int_ff[2] - dly_ff[0];
                comb_v[1] = comb_v[0] - dly_ff[1];
                comb_v[2] = comb_v[1] - dly_ff[2];
                if (sample_tick) begin
                    nxt_int[0] = int_ff[0] + x_in; // [RULE_06]
                    nxt_int[1] = int_ff[1] + int_ff[0];
                    nxt_int[2] = int_ff[2] + int_ff[1];
                end
                if (dump) begin
                    nxt_dly[0] = int_ff[2]; // [RULE_06]
                    nxt_dly[1] = comb_v[0];
                    nxt_dly[2] = comb_v[1];
                    nxt_cic    = comb_v[2];
                end
            end

            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    int_ff <= '{default: `DECIM_WORD_RST};
                    dly_ff <= '{default: `DECIM_WORD_RST};
                    cic_ff <= `DECIM_WORD_RST;
                end else begin
                    int_ff <= nxt_int;
                    dly_ff <= nxt_dly;
                    cic_ff <= nxt_cic;
                end
            end

            assign cic_word[gp] = cic_ff;
        end
    endgenerate

    // ---------------- shared compensation filter, paths in turn
    decim_pkg::seq_state_t state_ff;
    decim_pkg::seq_state_t nxt_state;
    logic [IX_W-1:0]       idx_ff;
    logic [IX_W-1:0]       nxt_idx;
    logic                  iss_ff;
    logic                  nxt_iss;
    logic [IX_W-1:0]       iss_idx_ff;
    logic [IX_W-1:0]       nxt_iss_idx;

    always_comb begin
        nxt_state   = state_ff;
        nxt_idx     = idx_ff;
        nxt_iss     = 1'b0;
        nxt_iss_idx = idx_ff;
        unique case (state_ff)
            decim_pkg::ST_IDLE: begin
                if (cic_rdy_ff) begin
                    nxt_state = decim_pkg::ST_RUN;
                    nxt_idx   = '0;
                end
            end
            decim_pkg::ST_RUN: begin
                nxt_iss = 1'b1;
                if (is_last_path(idx_ff)) begin
                    nxt_state = decim_pkg::ST_IDLE;
                    nxt_idx   = '0;
                end else begin
                    nxt_idx = idx_ff + IX_W'(1);
                end
            end
            default: begin
                nxt_state = decim_pkg::ST_IDLE;
                nxt_idx   = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff   <= decim_pkg::ST_IDLE;
            idx_ff     <= '0;
            iss_ff     <= 1'b0;
            iss_idx_ff <= '0;
        end else begin
            state_ff   <= nxt_state;
            idx_ff     <= nxt_idx;
            iss_ff     <= nxt_iss;
            iss_idx_ff <= nxt_iss_idx;
        end
    end

    // per-path filter history
    decim_pkg::word_t xh_ff  [NPATH][3];
    decim_pkg::word_t yh_ff  [NPATH][3];
    decim_pkg::word_t nxt_xh [NPATH][3];
    decim_pkg::word_t nxt_yh [NPATH][3];
    decim_pkg::word_t word_ff  [NPATH];
    decim_pkg::word_t nxt_word [NPATH];
    logic             vld_ff   [NPATH];
    logic             nxt_vld  [NPATH];
    decim_pkg::word_t iir_y;
    logic [IX_W-1:0]  rd_idx;

    // issue path is idx_ff; history is stable until its own result lands
    assign rd_idx = idx_ff;

    anti_droop_iir #(
        .W (W)
    ) u_iir (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .x0      (cic_word[rd_idx]),
        .x1      (xh_ff[rd_idx][0]),
        .x2      (xh_ff[rd_idx][1]),
        .x3      (xh_ff[rd_idx][2]),
        .y1      (yh_ff[rd_idx][0]),
        .y2      (yh_ff[rd_idx][1]),
        .y3      (yh_ff[rd_idx][2]),
        .y_out   (iir_y)
    );

    always_comb begin
        nxt_xh   = xh_ff;
        nxt_yh   = yh_ff;
        nxt_word = word_ff;
        for (int p = 0; p < NPATH; p++) begin
            nxt_vld[p] = 1'b0;
        end
        if (iss_ff) begin
            // cic word is unchanged until the next dump
            nxt_xh[iss_idx_ff][0]  = cic_word[iss_idx_ff];
            nxt_xh[iss_idx_ff][1]  = xh_ff[iss_idx_ff][0];
            nxt_xh[iss_idx_ff][2]  = xh_ff[iss_idx_ff][1];
            nxt_yh[iss_idx_ff][0]  = iir_y; // [RULE_07]
            nxt_yh[iss_idx_ff][1]  = yh_ff[iss_idx_ff][0];
            nxt_yh[iss_idx_ff][2]  = yh_ff[iss_idx_ff][1];
            nxt_word[iss_idx_ff]   = iir_y; // [RULE_08]
            nxt_vld[iss_idx_ff]    = 1'b1; // [RULE_08]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            xh_ff   <= '{default: '{default: `DECIM_WORD_RST}};
            yh_ff   <= '{default: '{default: `DECIM_WORD_RST}};
            word_ff <= '{default: `DECIM_WORD_RST};
            vld_ff  <= '{default: 1'b0};
        end else begin
            xh_ff   <= nxt_xh;
            yh_ff   <= nxt_yh;
            word_ff <= nxt_word;
            vld_ff  <= nxt_vld;
        end
    end

    assign v1_word    = word_ff[`DECIM_PATH_V1];
    assign v1_valid   = vld_ff[`DECIM_PATH_V1];
    assign v2_word    = word_ff[`DECIM_PATH_V2];
    assign v2_valid   = vld_ff[`DECIM_PATH_V2];
    assign i1_word    = word_ff[`DECIM_PATH_I1];
    assign i1_valid   = vld_ff[`DECIM_PATH_I1];
    assign i2_word    = word_ff[`DECIM_PATH_I2];
    assign i2_valid   = vld_ff[`DECIM_PATH_I2];
    assign temp_word  = word_ff[`DECIM_PATH_TEMP];
    assign temp_valid = vld_ff[`DECIM_PATH_TEMP];

endmodule // decimation_filter_front_end

// ==== tb/decim_front_sva.sv ====
`timescale 1ns/100ps
module decim_front_chk #(
    parameter int SAMPLE_DIV = 8,
    parameter int RATIO      = 128,
    parameter int W          = 24
) (
    input wire logic                ref_clk,
    input wire logic                rst_b,
    input wire logic                volt_mod_bit,
    input wire logic                cur1_mod_bit,
    input wire logic                cur2_mod_bit,
    input wire logic                temp_mod_bit,
    input wire logic signed [W-1:0] v1_word,
    input wire logic                v1_valid,
    input wire logic signed [W-1:0] v2_word,
    input wire logic                v2_valid,
    input wire logic signed [W-1:0] i1_word,
    input wire logic                i1_valid,
    input wire logic signed [W-1:0] i2_word,
    input wire logic                i2_valid,
    input wire logic signed [W-1:0] temp_word,
    input wire logic                temp_valid
);
    localparam int PERIOD = SAMPLE_DIV * RATIO;
    int   gap_ff;
    int   nxt_gap;
    logic seen_ff;
    logic nxt_seen;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // cycles since the last v1 word
    always_comb begin
        nxt_gap  = v1_valid ? 1 : gap_ff + 1;
        nxt_seen = seen_ff | v1_valid;
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_ff  <= 0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff  <= nxt_gap;
            seen_ff <= nxt_seen;
        end
    end
    valid_pulse_a: assert property (v1_valid |=> !v1_valid)
        else $error("v1 valid longer than one cycle");
    v2_order_a: assert property (v1_valid |=> v2_valid)
        else $error("v2 word not one cycle after v1");
    i1_order_a: assert property (v2_valid |=> i1_valid)
        else $error("i1 word not one cycle after v2");
    i2_order_a: assert property (i1_valid |=> i2_valid)
        else $error("i2 word not one cycle after i1");
    temp_order_a: assert property (i2_valid |=> temp_valid)
        else $error("temp word not one cycle after i2");
    v_pair_a: assert property (v2_valid |-> v2_word == v1_word)
        else $error("voltage paths disagree");
    v1_hold_a: assert property (!v1_valid |-> $stable(v1_word))
        else $error("v1 word changed without valid");
    temp_hold_a: assert property (!temp_valid |-> $stable(temp_word))
        else $error("temp word changed without valid");
    word_period_a: assert property (v1_valid && seen_ff |-> gap_ff == PERIOD)
        else $error("output word spacing wrong");
    gap_bound_a: assert property (seen_ff |-> gap_ff <= PERIOD)
        else $error("output word overdue");
    cover property (v1_valid && seen_ff);
    cover property (temp_valid && temp_word > 0);
    cover property (temp_valid && temp_word < 0);
endmodule // decim_front_chk

// ==== tb/mod_stream_model.sv ====
`timescale 1ns/100ps
// four modulator bit streams, one new bit per clock
module mod_stream_model (
    input  wire logic       ref_clk,
    input  wire logic [3:0] pat,
    input  wire logic       noise_en,
    input  wire logic [3:0] noise,
    output logic            volt_mod_bit,
    output logic            cur1_mod_bit,
    output logic            cur2_mod_bit,
    output logic            temp_mod_bit
);
    logic [3:0] bits;
    initial bits = 4'h0;
    always @(negedge ref_clk) bits <= noise_en ? noise : pat;
    assign volt_mod_bit = bits[0];
    assign cur1_mod_bit = bits[1];
    assign cur2_mod_bit = bits[2];
    assign temp_mod_bit = bits[3];
endmodule // mod_stream_model

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    localparam int SAMPLE_DIV = 8;
    localparam int RATIO      = 128;
    localparam int W          = 24;
    typedef struct {int path; logic signed [W-1:0] word;} note_t;
    logic                ref_clk, rst_b, noise_en, seen;
    logic [3:0]          pat, noise;
    logic [31:0]         rnd;
    wire                 vb, c1b, c2b, tb_;
    logic signed [W-1:0] v1_word, v2_word, i1_word, i2_word, temp_word;
    logic                v1_valid, v2_valid, i1_valid, i2_valid, temp_valid;
    note_t               notes[$];
    int                  miscompares, check_count, seed, gap;

    mod_stream_model i_mod (.ref_clk(ref_clk), .pat(pat), .noise_en(noise_en), .noise(noise),
        .volt_mod_bit(vb), .cur1_mod_bit(c1b), .cur2_mod_bit(c2b), .temp_mod_bit(tb_));
    decimation_filter_front_end #(.SAMPLE_DIV(SAMPLE_DIV), .RATIO(RATIO), .W(W)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .volt_mod_bit(vb), .cur1_mod_bit(c1b),
        .cur2_mod_bit(c2b), .temp_mod_bit(tb_), .v1_word(v1_word), .v1_valid(v1_valid),
        .v2_word(v2_word), .v2_valid(v2_valid), .i1_word(i1_word), .i1_valid(i1_valid),
        .i2_word(i2_word), .i2_valid(i2_valid), .temp_word(temp_word),
        .temp_valid(temp_valid));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp_word(input logic signed [W-1:0] got, input logic signed [W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_num(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            miscompares++;
            $display("BAD %0t: value %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic chk_path(input logic vld, input int p, input logic signed [W-1:0] w);
        note_t n;
        if (vld === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            cmp_num(p, n.path);
            cmp_word(w, n.word);
        end
    endtask

    // settled dc level of a constant stream
    function automatic logic signed [W-1:0] dc_of(input logic b);
        return b ? 24'h20_0000 : 24'hE0_0000;
    endfunction

    task automatic wait_words(input int n);
        int k;
        k = 0;
        for (int c = 0; c < n * 1100 && k < n; c++) begin
            @(negedge ref_clk);
            if (temp_valid === 1'b1)
                k++;
        end
        if (k < n) begin
            miscompares++;
            $display("BAD %0t: output word missing", $time);
            print_verdict();
        end
    endtask

    // results are settled by the falling edge
    always @(negedge ref_clk) begin
        if (rst_b === 1'b1) begin
            gap++;
            if (v1_valid === 1'b1) begin
                if (seen)
                    cmp_num(gap, SAMPLE_DIV * RATIO);
                gap  = 0;
                seen = 1'b1;
            end
            chk_path(v1_valid, 0, v1_word);
            chk_path(v2_valid, 1, v2_word);
            chk_path(i1_valid, 2, i1_word);
            chk_path(i2_valid, 3, i2_word);
            chk_path(temp_valid, 4, temp_word);
        end
    end

    always @(negedge ref_clk)
        if (noise_en)
            noise <= 4'($random(seed));

    initial begin
        seed = 98;
        rst_b = 1'b0;
        pat = 4'h0;
        noise = 4'h0;
        noise_en = 1'b0;
        seen = 1'b0;
        gap = 0;
        miscompares = 0;
        check_count = 0;
        repeat (2) @(negedge ref_clk);
        rst_b <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            rnd = $random(seed);
            pat <= (r == 0) ? 4'h5 : (r == 1) ? 4'hA : rnd[3:0];
            wait_words(14);
            // monitor is done with this falling edge before notes appear
            @(posedge ref_clk);
            notes.push_back('{0, dc_of(pat[0])});
            notes.push_back('{1, dc_of(pat[0])});
            notes.push_back('{2, dc_of(pat[1])});
            notes.push_back('{3, dc_of(pat[2])});
            notes.push_back('{4, dc_of(pat[3])});
            wait_words(1);
        end
        noise_en <= 1'b1;
        wait_words(3);
        cmp_num(notes.size(), 0);
        print_verdict();
    end
endmodule // testbench

bind decimation_filter_front_end decim_front_chk #(
    .SAMPLE_DIV(SAMPLE_DIV), .RATIO(RATIO), .W(W)) i_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .volt_mod_bit(volt_mod_bit),
    .cur1_mod_bit(cur1_mod_bit), .cur2_mod_bit(cur2_mod_bit), .temp_mod_bit(temp_mod_bit),
    .v1_word(v1_word), .v1_valid(v1_valid), .v2_word(v2_word), .v2_valid(v2_valid),
    .i1_word(i1_word), .i1_valid(i1_valid), .i2_word(i2_word), .i2_valid(i2_valid),
    .temp_word(temp_word), .temp_valid(temp_valid));
